// File: verilog/pdfi_pkg.sv
// shared constants and types for the dead-band and fault-interrupt block
`default_nettype none
package pdfi_pkg;
  localparam int unsigned PDFI_NUM_GEN = 4;
  localparam int unsigned PDFI_DLY_W = 16;
  localparam int unsigned PDFI_ADDR_W = 4;
  // register offsets (byte addresses)
  localparam logic [3:0] PDFI_OFS_CTRL = 4'h0;
  localparam logic [3:0] PDFI_OFS_DLY0 = 4'h4;
  localparam logic [3:0] PDFI_OFS_DLY1 = 4'h8;
  localparam logic [3:0] PDFI_OFS_DLY2 = 4'hC;
  // remaining offsets fill the gaps below 4'h7 in the same 4-bit address space
  localparam logic [3:0] PDFI_OFS_STAT = 4'h1;
  localparam logic [3:0] PDFI_OFS_CLR = 4'h2;
  localparam logic [3:0] PDFI_OFS_IEN = 4'h3;
  localparam logic [3:0] PDFI_OFS_LCLR = 4'h5;
  localparam logic [3:0] PDFI_OFS_DLY3 = 4'h6;
  // control register fields
  localparam int unsigned PDFI_CTRL_DB_LSB = 0;
  localparam int unsigned PDFI_CTRL_EXT_BIT = 4;
  localparam logic [31:0] PDFI_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] PDFI_IEN_RST = 4'h0;
  // delay register: rise in low half, fall in high half
  localparam int unsigned PDFI_RISE_LSB = 0;
  localparam int unsigned PDFI_FALL_LSB = 16;
  localparam logic [15:0] PDFI_DLY_RST = 16'h0000;

  typedef struct packed {
    logic [PDFI_DLY_W-1:0] falling_edge_delay_count;
    logic [PDFI_DLY_W-1:0] rising_edge_delay_count;
  } pdfi_dly_t;

  typedef struct packed {
    logic [PDFI_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pdfi_bus_t;
endpackage
`default_nettype wire

// File: verilog/pdfi_deadband.sv
// dead-band stage for one generator output pair
`timescale 1ns/100ps
`default_nettype none
module pdfi_deadband
  import pdfi_pkg::*;
#(
  parameter int unsigned DLY_W = PDFI_DLY_W
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic db_en,
  input wire logic [DLY_W-1:0] rise_dly,
  input wire logic [DLY_W-1:0] fall_dly,
  // raw generator signals
  input wire logic raw_a,
  input wire logic raw_b,
  // delayed pair
  output logic out_a,
  output logic out_b
);
  logic a_prev_ff;
  logic [DLY_W-1:0] cnt_ff;
  logic db_a_ff;
  logic db_b_ff;
  logic [DLY_W-1:0] nxt_cnt;
  logic nxt_db_a;
  logic nxt_db_b;

  wire rise_edge = raw_a & ~a_prev_ff;
  wire fall_edge = ~raw_a & a_prev_ff;
  wire cnt_done = (cnt_ff == '0);

  ////////////////////////////////////////////////////////////////////////
  // a delayed after its rise, b (inverted a) delayed after a's fall
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_db_a = db_a_ff;
    nxt_db_b = db_b_ff;
    if (rise_edge)
    begin
      nxt_db_b = 1'b0;
      nxt_cnt = rise_dly;
      if (rise_dly == '0)
        nxt_db_a = 1'b1;
    end
    else if (fall_edge)
    begin
      nxt_db_a = 1'b0;
      nxt_cnt = fall_dly;
      if (fall_dly == '0)
        nxt_db_b = 1'b1;
    end
    else if (!cnt_done)
    begin
      nxt_cnt = cnt_ff - 1'b1;
      if (cnt_ff == {{(DLY_W-1){1'b0}}, 1'b1})
      begin
        nxt_db_a = raw_a;
        nxt_db_b = ~raw_a;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      a_prev_ff <= 1'b0;
      cnt_ff <= '0;
      db_a_ff <= 1'b0;
      db_b_ff <= 1'b0;
    end
    else
    begin
      a_prev_ff <= raw_a;
      cnt_ff <= nxt_cnt;
      db_a_ff <= nxt_db_a;
      db_b_ff <= nxt_db_b;
    end
  end

  // bypass keeps the two comparator outputs independent
  assign out_a = db_en ? db_a_ff : raw_a;
  assign out_b = db_en ? db_b_ff : raw_b;
endmodule
`default_nettype wire

// File: verilog/pdfi_fault_flags.sv
// sticky per-generator fault interrupt flags
`timescale 1ns/100ps
`default_nettype none
module pdfi_fault_flags
  import pdfi_pkg::*;
#(
  parameter int unsigned NUM_GEN = PDFI_NUM_GEN
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // mode and sources
  input wire logic ext_mode,
  input wire logic [NUM_GEN-1:0] gen_fault_trig,
  input wire logic legacy_fault_pin,
  // clears
  input wire logic [NUM_GEN-1:0] clr_mask,
  // flags
  output logic [NUM_GEN-1:0] flags
);
  logic [NUM_GEN-1:0] flag_ff;
  logic [NUM_GEN-1:0] set_vec;

  // extended: one flag per generator; legacy: pin feeds flag 0 only
  assign set_vec = ext_mode ? gen_fault_trig
    : {{(NUM_GEN-1){1'b0}}, legacy_fault_pin};

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      flag_ff <= '0;
    else
      flag_ff <= set_vec | (flag_ff & ~clr_mask);
  end

  assign flags = flag_ff;
endmodule
`default_nettype wire

// File: verilog/pdfi_top.sv
// dead-band insertion and fault-interrupt status for four generators
`timescale 1ns/100ps
`default_nettype none
module pdfi_top
  import pdfi_pkg::*;
#(
  parameter int unsigned NUM_GEN = PDFI_NUM_GEN,
  parameter int unsigned DLY_W = PDFI_DLY_W
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [PDFI_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // generator comparator outputs, even = primary
  input wire logic [2*NUM_GEN-1:0] gen_raw,
  // fault sources
  input wire logic [NUM_GEN-1:0] gen_fault_trig,
  input wire logic legacy_fault_pin,
  // pwm outputs
  output logic [2*NUM_GEN-1:0] pwm_out,
  // interrupt
  output logic fault_irq
);
  pdfi_bus_t bus;
  logic [31:0] ctrl_ff;
  pdfi_dly_t dly_ff [NUM_GEN];
  logic [NUM_GEN-1:0] ien_ff;
  logic [31:0] rdata_ff;
  logic [2*NUM_GEN-1:0] pwm_ff;
  logic irq_ff;
  logic [NUM_GEN-1:0] flags;
  logic [2*NUM_GEN-1:0] db_out;
  logic [31:0] nxt_rdata;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire sel_ctrl = (bus.addr == PDFI_OFS_CTRL);
  wire sel_stat = (bus.addr == PDFI_OFS_STAT);
  wire sel_clr = (bus.addr == PDFI_OFS_CLR);
  wire sel_ien = (bus.addr == PDFI_OFS_IEN);
  wire sel_lclr = (bus.addr == PDFI_OFS_LCLR);
  wire ext_mode = ctrl_ff[PDFI_CTRL_EXT_BIT];
  wire [NUM_GEN-1:0] db_en = ctrl_ff[PDFI_CTRL_DB_LSB +: NUM_GEN];

  function automatic logic [3:0] dly_ofs(input int unsigned g);
    logic [3:0] r;
    r = PDFI_OFS_DLY0;
    unique case (g)
      0: r = PDFI_OFS_DLY0;
      1: r = PDFI_OFS_DLY1;
      2: r = PDFI_OFS_DLY2;
      default: r = PDFI_OFS_DLY3;
    endcase
    return r;
  endfunction

  // clear masks: full write, or the legacy path on flag 0 only
  wire [NUM_GEN-1:0] clr_full =
    (bus.wr && sel_clr) ? bus.wdata[NUM_GEN-1:0] : '0;
  wire [NUM_GEN-1:0] clr_legacy =
    {{(NUM_GEN-1){1'b0}}, bus.wr && sel_lclr};

  ////////////////////////////////////////////////////////////////////////
  // control and enable registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= PDFI_CTRL_RST;
      ien_ff <= PDFI_IEN_RST;
    end
    else
    begin
      if (bus.wr && sel_ctrl)
        ctrl_ff <= bus.wdata;
      if (bus.wr && sel_ien)
        ien_ff <= bus.wdata[NUM_GEN-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per generator: delay register and dead-band stage
  genvar g;
  generate
    for (g = 0; g < NUM_GEN; g++)
    begin : gen_pair
      wire sel_dly = (bus.addr == dly_ofs(g));
      always_ff @(posedge sys_clk or posedge sys_rst)
      begin
        if (sys_rst)
          dly_ff[g] <= '{PDFI_DLY_RST, PDFI_DLY_RST};
        else if (bus.wr && sel_dly)
          dly_ff[g] <= bus.wdata;
      end
      pdfi_deadband #(.DLY_W(DLY_W)) u_db (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .db_en(db_en[g]),
        .rise_dly(dly_ff[g].rising_edge_delay_count),
        .fall_dly(dly_ff[g].falling_edge_delay_count),
        .raw_a(gen_raw[2*g]),
        .raw_b(gen_raw[2*g+1]),
        .out_a(db_out[2*g]),
        .out_b(db_out[2*g+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // fault flags
  pdfi_fault_flags #(.NUM_GEN(NUM_GEN)) u_flags (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ext_mode(ext_mode),
    .gen_fault_trig(gen_fault_trig),
    .legacy_fault_pin(legacy_fault_pin),
    .clr_mask(clr_full | clr_legacy),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped and write-only addresses read zero
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (bus.rd)
    begin
      if (sel_ctrl)
        nxt_rdata = ctrl_ff;
      else if (sel_stat)
        nxt_rdata[NUM_GEN-1:0] = flags;
      else if (sel_ien)
        nxt_rdata[NUM_GEN-1:0] = ien_ff;
      else
        for (int i = 0; i < NUM_GEN; i++)
          if (bus.addr == dly_ofs(i))
            nxt_rdata = dly_ff[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_ff <= 32'h0000_0000;
      pwm_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      pwm_ff <= db_out;
      irq_ff <= |(flags & ien_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign pwm_out = pwm_ff;
  assign fault_irq = irq_ff;
endmodule
`default_nettype wire

// File: verification/pdfi_top_sva.sv
// port assertions for the dead-band and fault-interrupt block
`timescale 1ns/100ps
`default_nettype none
module pdfi_top_sva
  import pdfi_pkg::*;
#(
  parameter int unsigned NUM_GEN = PDFI_NUM_GEN
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [PDFI_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // pins
  input wire logic [2*NUM_GEN-1:0] gen_raw,
  input wire logic [NUM_GEN-1:0] gen_fault_trig,
  input wire logic legacy_fault_pin,
  input wire logic [2*NUM_GEN-1:0] pwm_out,
  input wire logic fault_irq
);
  logic [4:0] ctl_ff;
  logic [NUM_GEN-1:0] ien_ff;
  wire logic ext = ctl_ff[PDFI_CTRL_EXT_BIT];
  // an enabled flag would be set at this edge
  wire logic src = ext ? |(gen_fault_trig & ien_ff)
    : legacy_fault_pin & ien_ff[0];
  wire logic clr_wr = reg_wr && reg_addr == PDFI_OFS_CLR;
  wire logic lclr_wr = reg_wr && reg_addr == PDFI_OFS_LCLR;
  // shadow of control and enable registers
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ctl_ff <= 5'h00;
      ien_ff <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == PDFI_OFS_CTRL)
        ctl_ff <= reg_wdata[4:0];
      if (reg_addr == PDFI_OFS_IEN)
        ien_ff <= reg_wdata[NUM_GEN-1:0];
    end
  ///////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bypass_pass_a: assert property (
    (ctl_ff[3:0] == 4'h0 && $stable(gen_raw))[*3] |-> pwm_out == gen_raw)
    else $error("bypass output differs from raw");
  db_exclusive_a: assert property (
    $past(ctl_ff[0], 3) && ctl_ff[0] |-> !(pwm_out[0] && pwm_out[1]))
    else $error("both outputs of a dead-band pair high");
  ext_set_a: assert property (
    ext && |(gen_fault_trig & ien_ff) && !reg_wr |-> ##2 fault_irq)
    else $error("trigger did not raise the interrupt");
  legacy_set_a: assert property (
    !ext && legacy_fault_pin && ien_ff[0] && !reg_wr |-> ##2 fault_irq)
    else $error("fault pin did not raise the interrupt");
  flag_sticky_a: assert property (
    fault_irq && !$past(reg_wr) |=> fault_irq)
    else $error("interrupt dropped without a write");
  clear_all_a: assert property (
    clr_wr && (ien_ff & ~reg_wdata[NUM_GEN-1:0]) == '0 && !src
    |-> ##2 !fault_irq)
    else $error("clear left the interrupt high");
  legacy_clear_a: assert property (
    lclr_wr && ien_ff == 4'h1 && !src |-> ##2 !fault_irq)
    else $error("legacy clear missed the first flag");
  legacy_keep_a: assert property (
    lclr_wr && !ien_ff[0] && fault_irq && !$past(reg_wr) |-> ##2 fault_irq)
    else $error("legacy clear touched another flag");
  cover property (ext && gen_fault_trig != '0);
  cover property (lclr_wr && fault_irq);
  cover property (ctl_ff[0] && pwm_out[0]);
endmodule
`default_nettype wire

// File: verification/pdfi_top_tb.sv
// self-checking bench for the dead-band and fault-interrupt block
`timescale 1ns/100ps
`default_nettype none
module pdfi_top_tb
  import pdfi_pkg::*;
;
  logic sys_clk, sys_rst, reg_wr, reg_rd, legacy_fault_pin, fault_irq;
  logic [3:0] reg_addr, gen_fault_trig;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] gen_raw, pwm_out;
  int num_errors = 0, check_count = 0, n;
  // raw input in the high byte, expected output in the low byte
  logic [15:0] rows [4] = '{16'h0101, 16'h0202, 16'hA5A5, 16'hFFFF};
  logic [3:0] dofs [4] = '{PDFI_OFS_DLY0, PDFI_OFS_DLY1, PDFI_OFS_DLY2,
    PDFI_OFS_DLY3};
  pdfi_top dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .gen_raw, .gen_fault_trig, .legacy_fault_pin, .pwm_out,
    .fault_irq);
  initial
  begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  ///////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // cycles until an output reaches a level, bounded
  task automatic meas(int b, logic v);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    while (pwm_out[b] !== v && n < 60);
    if (n >= 60)
    begin
      chk("wait", 32'h0, n);
      results();
    end
  endtask
  task automatic pulse(logic [3:0] t, logic p);
    @(posedge sys_clk);
    gen_fault_trig <= t;
    legacy_fault_pin <= p;
    @(posedge sys_clk);
    gen_fault_trig <= 4'h0;
    legacy_fault_pin <= 1'h0;
  endtask
  ///////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    gen_raw = 8'h00;
    gen_fault_trig = 4'h0;
    legacy_fault_pin = 1'h0;
    repeat (20) @(posedge sys_clk);
    chk("pwm", 32'h0, pwm_out);
    sys_rst <= 1'h0;
    rd(PDFI_OFS_CTRL, 32'h0);
    rd(PDFI_OFS_IEN, 32'h0);
    rd(PDFI_OFS_STAT, 32'h0);
    rd(4'h7, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      gen_raw <= rows[i][15:8];
      repeat (3) @(posedge sys_clk);
      #1 chk("pwm", rows[i][7:0], pwm_out);
    end
    @(posedge sys_clk);
    gen_raw <= 8'h00;
    $display("bypass test done");
    for (int g = 0; g < 4; g++)
    begin
      wr(dofs[g], {16'(g + 4), 16'(g + 1)});
      rd(dofs[g], {16'(g + 4), 16'(g + 1)});
      wr(PDFI_OFS_CTRL, 32'(1 << g));
      meas(2 * g + 1, 1'h1);
      @(posedge sys_clk);
      gen_raw <= 8'(1 << (2 * g));
      meas(2 * g + 1, 1'h0);
      chk("lag", 32'h2, n);
      meas(2 * g, 1'h1);
      chk("rise", g + 1, n);
      @(posedge sys_clk);
      gen_raw <= 8'h00;
      meas(2 * g, 1'h0);
      chk("lag", 32'h2, n);
      meas(2 * g + 1, 1'h1);
      chk("fall", g + 4, n);
    end
    $display("dead band test done");
    wr(PDFI_OFS_CTRL, 32'h10);
    wr(PDFI_OFS_IEN, 32'hF);
    pulse(4'h5, 1'h0);
    rd(PDFI_OFS_STAT, 32'h5);
    chk("irq", 32'h1, fault_irq);
    wr(PDFI_OFS_CLR, 32'h1);
    pulse(4'h0, 1'h1);
    rd(PDFI_OFS_STAT, 32'h4);
    wr(PDFI_OFS_IEN, 32'hE);
    wr(PDFI_OFS_LCLR, 32'h1);
    rd(PDFI_OFS_STAT, 32'h4);
    wr(PDFI_OFS_CLR, 32'hF);
    rd(PDFI_OFS_STAT, 32'h0);
    chk("irq", 32'h0, fault_irq);
    wr(PDFI_OFS_IEN, 32'h7);
    pulse(4'h8, 1'h0);
    rd(PDFI_OFS_STAT, 32'h8);
    chk("irq", 32'h0, fault_irq);
    wr(PDFI_OFS_IEN, 32'hF);
    rd(PDFI_OFS_IEN, 32'hF);
    chk("irq", 32'h1, fault_irq);
    // trigger held through a clear of its own bit
    @(posedge sys_clk);
    gen_fault_trig <= 4'h2;
    wr(PDFI_OFS_CLR, 32'hA);
    gen_fault_trig <= 4'h0;
    rd(PDFI_OFS_STAT, 32'h2);
    wr(PDFI_OFS_CTRL, 32'h0);
    wr(PDFI_OFS_CLR, 32'hF);
    wr(PDFI_OFS_IEN, 32'h1);
    pulse(4'hF, 1'h0);
    rd(PDFI_OFS_STAT, 32'h0);
    pulse(4'h0, 1'h1);
    rd(PDFI_OFS_STAT, 32'h1);
    wr(PDFI_OFS_LCLR, 32'h0);
    rd(PDFI_OFS_STAT, 32'h0);
    chk("irq", 32'h0, fault_irq);
    $display("fault test done");
    // reset in mid-run with a flag set, dead band on and delays loaded
    wr(PDFI_OFS_CTRL, 32'h11);
    pulse(4'h1, 1'h0);
    rd(PDFI_OFS_STAT, 32'h1);
    @(posedge sys_clk);
    #1 chk("rdata", 32'h0, reg_rdata);
    chk("irq", 32'h1, fault_irq);
    @(posedge sys_clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    #1 chk("pwm", 32'h0, pwm_out);
    chk("irq", 32'h0, fault_irq);
    @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd(PDFI_OFS_STAT, 32'h0);
    rd(PDFI_OFS_CTRL, 32'h0);
    rd(dofs[0], 32'h0);
    $display("mid-run reset test done");
    results();
  end
endmodule
bind pdfi_top pdfi_top_sva #(.NUM_GEN(NUM_GEN)) sva_i (.sys_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gen_raw,
  .gen_fault_trig, .legacy_fault_pin, .pwm_out, .fault_irq);
`default_nettype wire
